/* core/tmc_pkg.sv */
package tmc_pkg;
	// Register offsets (byte addresses)
	localparam logic [11:0] CFG_OFF      = 12'h000;
	localparam logic [11:0] FIRST_MR_OFF = 12'h004;
	localparam logic [11:0] SECOND_MR_OFF = 12'h008;
	localparam logic [11:0] CTL_OFF      = 12'h00c;

	// Control field positions and register field widths
	localparam int CTL_FIRST_TRIG_BIT = 5;
	localparam int CTL_FIRST_INV_BIT  = 6;
	localparam int CTL_SECOND_ON_BIT  = 8;
	localparam int CTL_SECOND_FRZ_BIT = 9;
	localparam int CTL_SECOND_EDGE_LO = 10;
	localparam int CFG_WIDTH          = 3;
	localparam int MR_WIDTH           = 4;

	// Reset values
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [3:0] MR_RESET  = 4'h0;

	// Configuration codes
	localparam logic [2:0] CFG_COMBINED = 3'h0;

	// Mode field encodings
	localparam logic [1:0] MODE_RESERVED = 2'h0;
	localparam logic [1:0] MODE_ONESHOT  = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam logic [1:0] MODE_CAPTURE  = 2'h3;

	// Edge field encodings
	localparam logic [1:0] EDGE_RISING  = 2'h0;
	localparam logic [1:0] EDGE_FALLING = 2'h1;
	localparam logic [1:0] EDGE_RSVD    = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	typedef enum logic [1:0] {
		TMC_ARR_COMBINED,
		TMC_ARR_RTC,
		TMC_ARR_SPLIT,
		TMC_ARR_RESERVED
	} tmc_arr_t;

	// Register bus request
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tmc_bus_t;

	// Per-timer drive toward the counters
	typedef struct packed {
		logic [1:0] mode;
		logic       on;
		logic       run;
		logic [1:0] edge_sel;
	} tmc_drive_t;

	// Whole module state
	typedef struct packed {
		logic [2:0]  global_width_config;
		logic [3:0]  first_timer_mode_reg;
		logic [3:0]  second_timer_mode_reg;
		logic [1:0]  second_capture_edge_sel;
		logic        second_debug_freeze;
		logic        second_timer_on;
		logic        first_pulse_invert;
		logic        first_converter_trigger_on;
		logic [31:0] rdata;
		logic        split;
		logic        combined;
		logic [1:0]  second_mode;
		logic        second_run;
		logic        first_pwm_out;
		logic        converter_trigger;
	} tmc_state_t;
endpackage

/* core/tmc_timer_mode_control.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
// Notes on behaviour
// (RULE1) Second mode field: 1 one-shot, 2 periodic, 3 capture, 0 reserved.
// (RULE2) In split sixteen-bit arrangement the second mode field sets second timer mode.
// (RULE3) In combined arrangement the second mode register is ignored; first one used.
// (RULE4) Control bits 11:10 pick capture edge: 0 rising, 1 falling, 3 both.
// (RULE5) Control bit 9 set freezes second timer while debugger halts processor.
// (RULE6) Freeze setting has no effect while processor runs normally.
// (RULE7) Control bit 8 enables the second timer; clear disables it.
// (RULE8) Control bit 6 inverts the first timer pulse output.
// (RULE9) Control bit 5 enables the first timer converter trigger.
// (RULE10) Configuration zero selects the combined thirty-two-bit arrangement.
// (RULE11) Configuration four to seven selects split arrangement, modes from low two bits.
// (RULE12) All control fields reset to zero: disabled, uninverted, untriggered, rising.
module tmc_timer_mode_control (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire tmc_pkg::tmc_bus_t bus,
	output logic [31:0]            rdata,
	input  wire logic              debug_halt,
	input  wire logic              first_pwm_raw,
	input  wire logic              first_trigger_event,
	output logic                   split_mode,
	output logic                   combined_mode,
	output logic [1:0]             second_mode,
	output logic                   second_enable,
	output logic                   second_count_run,
	output logic [1:0]             second_edge,
	output logic                   first_pwm_out,
	output logic                   converter_trigger
);
	tmc_pkg::tmc_state_t st;
	tmc_pkg::tmc_state_t next_st;
	logic [2:0]          cfg_v;
	logic [3:0]          tbm_v;
	logic                frz_v;
	logic                on_v;

	// Register writes, read mux and derived outputs
	always_comb begin
		next_st = st;
		next_st.rdata = 32'h0000_0000;
		if (bus.wr) begin
			if (bus.addr == tmc_pkg::CFG_OFF) begin
				next_st.global_width_config = bus.wdata[tmc_pkg::CFG_WIDTH-1:0];
			end else if (bus.addr == tmc_pkg::FIRST_MR_OFF) begin
				next_st.first_timer_mode_reg = bus.wdata[tmc_pkg::MR_WIDTH-1:0];
			end else if (bus.addr == tmc_pkg::SECOND_MR_OFF) begin
				next_st.second_timer_mode_reg = bus.wdata[tmc_pkg::MR_WIDTH-1:0];
			end else if (bus.addr == tmc_pkg::CTL_OFF) begin
				next_st.second_capture_edge_sel =
					bus.wdata[tmc_pkg::CTL_SECOND_EDGE_LO+:2]; // see (RULE4)
				next_st.second_debug_freeze = bus.wdata[tmc_pkg::CTL_SECOND_FRZ_BIT];
				next_st.second_timer_on     = bus.wdata[tmc_pkg::CTL_SECOND_ON_BIT];
				next_st.first_pulse_invert  = bus.wdata[tmc_pkg::CTL_FIRST_INV_BIT];
				next_st.first_converter_trigger_on =
					bus.wdata[tmc_pkg::CTL_FIRST_TRIG_BIT];
			end
		end
		// Reads return current register contents one cycle later
		if (bus.rd) begin
			if (bus.addr == tmc_pkg::CFG_OFF) begin
				next_st.rdata[2:0] = st.global_width_config;
			end else if (bus.addr == tmc_pkg::FIRST_MR_OFF) begin
				next_st.rdata[3:0] = st.first_timer_mode_reg;
			end else if (bus.addr == tmc_pkg::SECOND_MR_OFF) begin
				next_st.rdata[3:0] = st.second_timer_mode_reg;
			end else if (bus.addr == tmc_pkg::CTL_OFF) begin
				next_st.rdata[tmc_pkg::CTL_SECOND_EDGE_LO+:2] = st.second_capture_edge_sel;
				next_st.rdata[tmc_pkg::CTL_SECOND_FRZ_BIT] = st.second_debug_freeze;
				next_st.rdata[tmc_pkg::CTL_SECOND_ON_BIT]  = st.second_timer_on;
				next_st.rdata[tmc_pkg::CTL_FIRST_INV_BIT]  = st.first_pulse_invert;
				next_st.rdata[tmc_pkg::CTL_FIRST_TRIG_BIT] = st.first_converter_trigger_on;
			end
		end
		// Derived drive from the post-write register values
		cfg_v = next_st.global_width_config;
		tbm_v = next_st.second_timer_mode_reg;
		frz_v = next_st.second_debug_freeze;
		on_v  = next_st.second_timer_on;
		next_st.combined = (cfg_v == tmc_pkg::CFG_COMBINED); // see (RULE10)
		next_st.split    = cfg_v[2]; // see (RULE11)
		if (next_st.split) begin
			next_st.second_mode = tbm_v[1:0]; // see (RULE1) see (RULE2)
		end else if (next_st.combined) begin
			next_st.second_mode = next_st.first_timer_mode_reg[1:0]; // see (RULE3)
		end else begin
			next_st.second_mode = tmc_pkg::MODE_RESERVED;
		end
		// Freeze only matters while the debugger holds the processor
		next_st.second_run = on_v && !(frz_v && debug_halt); // see (RULE5) see (RULE6) see (RULE7)
		next_st.first_pwm_out = first_pwm_raw ^ next_st.first_pulse_invert; // see (RULE8)
		next_st.converter_trigger =
			first_trigger_event && next_st.first_converter_trigger_on; // see (RULE9)
	end

	// State register; everything clears on reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0; // see (RULE12)
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state flops
	assign rdata             = st.rdata;
	assign split_mode        = st.split;
	assign combined_mode     = st.combined;
	assign second_mode       = st.second_mode;
	assign second_enable     = st.second_timer_on;
	assign second_count_run  = st.second_run;
	assign second_edge       = st.second_capture_edge_sel;
	assign first_pwm_out     = st.first_pwm_out;
	assign converter_trigger = st.converter_trigger;
endmodule

/* bench/tmc_monitor.sv */
`timescale 1ns/1ns
module tmc_monitor (
	input logic              clk,
	input logic              rstn,
	input tmc_pkg::tmc_bus_t bus,
	input logic              debug_halt,
	input logic              first_pwm_raw,
	input logic              first_trigger_event,
	input logic              split_mode,
	input logic              combined_mode,
	input logic              second_enable,
	input logic              second_count_run,
	input logic [1:0]        second_edge,
	input logic              first_pwm_out,
	input logic              converter_trigger
);
	// Writes to the control and configuration words
	wire ctl_wr = bus.wr && bus.addr == 12'h00c;
	wire cfg_wr = bus.wr && bus.addr == 12'h000;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Field writes show up at the outputs one edge later
	a_enable_wr: assert property (ctl_wr |=> second_enable == $past(bus.wdata[8]))
		else $error("enable not taken");
	a_edge_wr: assert property (ctl_wr |=> second_edge == $past(bus.wdata[11:10]))
		else $error("edge not taken");
	a_run_normal: assert property (!bus.wr && !debug_halt |=> second_count_run == $past(second_enable))
		else $error("run differs from enable");
	a_run_needs_en: assert property (second_count_run |-> second_enable)
		else $error("run while disabled");
	a_pwm_follow: assert property (!bus.wr && $changed(first_pwm_raw) |=> $changed(first_pwm_out))
		else $error("pwm did not follow");
	a_trig_cause: assert property (converter_trigger |-> $past(first_trigger_event))
		else $error("trigger without event");
	a_comb_cfg: assert property (cfg_wr |=> combined_mode == ($past(bus.wdata[2:0]) == 3'h0))
		else $error("combined wrong");
	a_split_cfg: assert property (cfg_wr |=> split_mode == $past(bus.wdata[2]))
		else $error("split wrong");
	a_modes_excl: assert property (!(split_mode && combined_mode))
		else $error("both arrangements");
	// Main scenarios reached
	c_ctl_wr: cover property (ctl_wr);
	c_trig: cover property (converter_trigger);
	c_split: cover property (split_mode);
	c_frozen: cover property (second_enable && !second_count_run);
endmodule
bind tmc_timer_mode_control tmc_monitor u_mon (.clk(clk), .rstn(rstn), .bus(bus),
	.debug_halt(debug_halt), .first_pwm_raw(first_pwm_raw),
	.first_trigger_event(first_trigger_event), .split_mode(split_mode),
	.combined_mode(combined_mode), .second_enable(second_enable),
	.second_count_run(second_count_run), .second_edge(second_edge),
	.first_pwm_out(first_pwm_out), .converter_trigger(converter_trigger));

/* bench/tmc_far_side.sv */
`timescale 1ns/1ns
module tmc_far_side (
	input  logic clk,
	input  logic rstn,
	input  logic halt_req,
	input  logic converter_trigger,
	output logic debug_halt,
	output int   trig_seen
);
	// Debugger halt follows its request; converter counts trigger pulses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			debug_halt <= 1'b0;
			trig_seen <= 0;
		end else begin
			debug_halt <= halt_req;
			trig_seen <= trig_seen + int'(converter_trigger);
		end
	end
endmodule

/* bench/tmc_timer_mode_control_bench.sv */
`timescale 1ns/1ns
module tmc_timer_mode_control_bench;
	logic clk = 0, rstn = 0, halt_req = 0, raw = 0, tev = 0, halt;
	logic split, comb, en, run, pwm, trig;
	logic [1:0] smode, edge_o;
	logic [31:0] rdata;
	tmc_pkg::tmc_bus_t bus = '0;
	int errors = 0, checked = 0, trig_seen;
	initial forever #10 clk = ~clk;
	tmc_timer_mode_control dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.debug_halt(halt), .first_pwm_raw(raw), .first_trigger_event(tev), .split_mode(split),
		.combined_mode(comb), .second_mode(smode), .second_enable(en), .second_count_run(run),
		.second_edge(edge_o), .first_pwm_out(pwm), .converter_trigger(trig));
	tmc_far_side far (.clk(clk), .rstn(rstn), .halt_req(halt_req), .converter_trigger(trig),
		.debug_halt(halt), .trig_seen(trig_seen));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Bus cycles; outputs are looked at just after the taking edge
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e);
		@(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) bus.rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task automatic t_ctl;
		chk("reset outs", 32'h0, {en, run, edge_o, pwm, trig});
		rd(12'h00c, 32'h0);
		wr(12'h00c, 32'hffff_ffff);
		rd(12'h00c, 32'h0000_0f60);
		rd(12'h010, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(12'h00c, 32'(i) << 10);
			chk("edge", 32'(edge_o), 32'(i));
		end
	endtask
	task automatic t_mode;
		wr(12'h000, 32'h7);
		for (int m = 1; m < 4; m++) begin
			wr(12'h008, 32'(m));
			chk("split mode", 32'(8 + m), {split, comb, smode});
		end
		wr(12'h004, 32'h2);
		wr(12'h000, 32'h0);
		chk("comb mode", 32'h6, {split, comb, smode});
		wr(12'h000, 32'h1);
		chk("other cfg", 32'h0, {split, comb, smode});
		rd(12'h000, 32'h1);
	endtask
	task automatic t_freeze;
		wr(12'h00c, 32'h300);
		@(posedge clk) halt_req <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("frozen", 32'h0, run);
		wr(12'h00c, 32'h100);
		chk("halt run", 32'h1, run);
		@(posedge clk) halt_req <= 1'b0;
		wr(12'h00c, 32'h300);
		chk("normal run", 32'h1, run);
	endtask
	task automatic t_pwm;
		wr(12'h00c, 32'h60);
		@(posedge clk) raw <= 1'b1;
		@(posedge clk) tev <= 1'b1;
		@(posedge clk) tev <= 1'b0;
		#1 chk("inverted", 32'h1, {pwm, trig});
		wr(12'h00c, 32'h0);
		@(posedge clk) tev <= 1'b1;
		@(posedge clk) tev <= 1'b0;
		#1 chk("plain", 32'h2, {pwm, trig});
		chk("trig count", 32'h1, trig_seen);
	endtask
	task automatic end_sim;
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_ctl;
		t_mode;
		t_freeze;
		t_pwm;
		end_sim;
	end
	// Watchdog well past the expected run length
	initial begin
		#100000;
		errors++;
		end_sim;
	end
endmodule
